// File: dacc_checker.sv
// port assertions for the converter control block
`include "dacc_map.svh"
`default_nettype none
module dacc_checker
   import dacc_pkg::*;
   (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // pins
   input wire logic ext_clk_i,
   input wire logic sample_hold_trigger_i,
   input wire logic cs_n_i,
   input wire logic wr_n_i,
   input wire logic [11:0] bus_data_i,
   // outputs
   input wire logic [11:0] bus_data_o,
   input wire logic bus_data_oe_o,
   input wire logic busy_o,
   input wire logic hold_o,
   input wire dacc_mux_s mux_sel_o,
   input wire logic [9:0] programmable_reference_output_o
   );
   timeunit 1ns;
   timeprecision 1ns;
   logic ext_q;
   logic [4:0] ecnt;
   logic wr_q;
   logic nap_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // pin edges inside one hold window; busy starts late in auto sleep
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ext_q <= 1'b0;
         ecnt <= 5'h00;
         wr_q <= 1'b1;
         nap_q <= 1'b0;
      end
      else
      begin
         ext_q <= ext_clk_i;
         ecnt <= hold_o ? ecnt + 5'(ext_clk_i & ~ext_q) : 5'h00;
         wr_q <= wr_n_i;
         // auto sleep mode as written on the pins
         if (wr_n_i && !wr_q && !cs_n_i && !bus_data_i[`DACC_WR_SEL_BIT])
         begin
            nap_q <= bus_data_i[`DACC_WR_NAP_BIT];
         end
      end
   end
   sequence desel_s; cs_n_i[*4]; endsequence
   sequence sel_s; !cs_n_i[*4]; endsequence
   sequence wr_idle_s; wr_n_i[*7]; endsequence
   oe_off_a: assert property (desel_s |-> !bus_data_oe_o)
      else $error("data driven while deselected");
   oe_on_a: assert property (sel_s |-> bus_data_oe_o)
      else $error("data not driven while selected");
   data_keep_a: assert property (desel_s ##1 desel_s |-> $stable(bus_data_o))
      else $error("data changed while deselected");
   cfg_keep_a: assert property (wr_idle_s |-> $stable(mux_sel_o) && $stable(programmable_reference_output_o))
      else $error("setting changed without write");
   hold_busy_a: assert property (busy_o |-> hold_o)
      else $error("busy without hold");
   hold_rise_a: assert property ($fell(sample_hold_trigger_i) && !hold_o |-> ##[2:4] hold_o && (busy_o || nap_q))
      else $error("trigger did not start hold");
   nap_busy_a: assert property (nap_q && $rose(hold_o) |-> !busy_o ##[1:20] busy_o)
      else $error("auto sleep busy not at conversion start");
   edge_count_a: assert property ($fell(busy_o) |-> ecnt == 5'h0E && $fell(hold_o))
      else $error("busy fell on wrong edge");
   edge_max_a: assert property (busy_o |-> ecnt <= 5'h0E)
      else $error("busy held past last edge");
   busy_drop_a: assert property ($rose(ecnt == 5'h0E) |-> ##[1:5] !busy_o)
      else $error("busy late after last edge");
endmodule // dacc_checker
bind dacc_conv_ctrl dacc_checker chk (.clk_sys_i, .reset_i, .ext_clk_i, .sample_hold_trigger_i, .cs_n_i,
   .wr_n_i, .bus_data_i, .bus_data_o, .bus_data_oe_o, .busy_o, .hold_o, .mux_sel_o,
   .programmable_reference_output_o);
`default_nettype wire

// File: dacc_conv_ctrl.sv
// conversion control and parallel host port of a dual simultaneous converter
`include "dacc_map.svh"
`default_nettype none

module dacc_conv_ctrl
   import dacc_pkg::*;
   #(
   parameter int SYS_CLK_PS = `DACC_SYS_CLK_PS
   )
   (
   // clock and power-on reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // conversion pins
   input wire logic ext_clk_i,
   input wire logic sample_hold_trigger_i,
   // parallel host port
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [11:0] bus_data_i,
   output logic [11:0] bus_data_o,
   output logic bus_data_oe_o,
   // digitised converter inputs
   input wire logic [11:0] conv_a_i,
   input wire logic [11:0] conv_b_i,
   // status and analog controls
   output logic busy_o,
   output logic hold_o,
   output dacc_mux_s mux_sel_o,
   output logic [9:0] programmable_reference_output_o
   );

   localparam int CONV_CLKS = `DACC_CONV_CLKS;
   localparam int BUSY_EDGE = `DACC_BUSY_EDGE;
   localparam int ACQ_CYC_I = (`DACC_ACQ_MIN_PS + SYS_CLK_PS - 1) / SYS_CLK_PS;
   localparam int SETUP_CYC_I = (`DACC_TRIG_SETUP_PS + SYS_CLK_PS - 1) / SYS_CLK_PS;
   localparam logic [2:0] ACQ_CYC = 3'(ACQ_CYC_I < 1 ? 1 : ACQ_CYC_I);
   localparam logic [1:0] SETUP_CYC = 2'(SETUP_CYC_I < 1 ? 1 : SETUP_CYC_I);

   if (SYS_CLK_PS < 1 || ACQ_CYC_I > 7 || SETUP_CYC_I > 3)
   begin : g_clk_check
      $error("dacc_conv_ctrl: SYS_CLK_PS out of range");
   end

   // selector decode for both modes
   function automatic dacc_mux_s mux_decode(input logic [1:0] sel, input logic pseudo);
      dacc_mux_s m;
      m.pos = DACC_IN0_POS;
      m.neg = DACC_IN0_NEG;
      if (pseudo)
      begin
         // channel zero inverting input is the common reference
         if (sel == 2'h1)
         begin
            m.pos = DACC_IN1_NEG;
         end
         else if (sel == 2'h2)
         begin
            m.pos = DACC_IN1_POS;
         end
      end
      else if (sel == 2'h3)
      begin
         m.pos = DACC_IN1_POS;
         m.neg = DACC_IN1_NEG;
      end
      return m;
   endfunction

   dacc_pins_s pin_lvl;
   dacc_pins_s pin_rise;
   dacc_pins_s pin_fall;
   logic [11:0] bus_data_sync;

   dacc_sync_edge #(
      .WIDTH(5),
      .IDLE(`DACC_PIN_IDLE)
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .async_i({ext_clk_i, sample_hold_trigger_i, cs_n_i, rd_n_i, wr_n_i}),
      .level_o(pin_lvl),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   // data travels the same two flops as the write strobe
   dacc_sync_edge #(
      .WIDTH(12)
   ) u_data_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .async_i(bus_data_i),
      .level_o(bus_data_sync),
      .rise_o(),
      .fall_o()
   );

   dacc_ctrl_s r_reg;
   dacc_ctrl_s r_next;
   logic cs_act;

   always_comb
   begin
      r_next = r_reg;
      cs_act = ~pin_lvl.cs_n;
      case (r_reg.state)
         DACC_ST_SAMPLE:
         begin
            if (r_reg.acq_cnt != 3'h0)
            begin
               r_next.acq_cnt = r_reg.acq_cnt - 3'h1;
            end
            if (pin_fall.trig_n && r_reg.acq_cnt == 3'h0)
            begin
               r_next.state = DACC_ST_ARMED;
               r_next.hold = 1'b1;
               r_next.samp_a = conv_a_i;
               r_next.samp_b = conv_b_i;
               r_next.busy = ~r_reg.auto_nap;
               r_next.setup_cnt = SETUP_CYC;
            end
         end
         DACC_ST_ARMED:
         begin
            if (r_reg.setup_cnt != 2'h0)
            begin
               r_next.setup_cnt = r_reg.setup_cnt - 2'h1;
            end
            else if (pin_rise.ext_clk)
            begin
               r_next.state = DACC_ST_CONV;
               r_next.edge_cnt = 4'h1;
               r_next.busy = 1'b1;
            end
         end
         DACC_ST_CONV:
         begin
            if (pin_rise.ext_clk)
            begin
               r_next.edge_cnt = r_reg.edge_cnt + 4'h1;
               if (r_reg.edge_cnt + 4'h1 == 4'(CONV_CLKS))
               begin
                  r_next.res_a = r_reg.samp_a;
                  r_next.res_b = r_reg.samp_b;
               end
               if (r_reg.edge_cnt + 4'h1 == 4'(BUSY_EDGE))
               begin
                  r_next.busy = 1'b0;
                  r_next.hold = 1'b0;
                  r_next.rd_ptr = 1'b0;
                  r_next.acq_cnt = ACQ_CYC;
                  r_next.state = DACC_ST_SAMPLE;
               end
            end
         end
         default:
         begin
            r_next.state = DACC_ST_SAMPLE;
         end
      endcase
      r_next.data_oe = cs_act;
      if (cs_act && pin_fall.rd_n)
      begin
         r_next.data = r_reg.rd_ptr ? r_reg.res_b : r_reg.res_a;
         r_next.rd_ptr = ~r_reg.rd_ptr;
      end
      if (cs_act && pin_rise.wr_n)
      begin
         if (bus_data_sync[`DACC_WR_SEL_BIT])
         begin
            r_next.ref_code = bus_data_sync[`DACC_WR_REF_HI:`DACC_WR_REF_LO];
         end
         else
         begin
            r_next.chsel = bus_data_sync[`DACC_WR_CHSEL_HI:`DACC_WR_CHSEL_LO];
            r_next.pseudo = bus_data_sync[`DACC_WR_PSEUDO_BIT];
            r_next.auto_nap = bus_data_sync[`DACC_WR_NAP_BIT];
         end
      end
      r_next.mux = mux_decode(r_next.chsel, r_next.pseudo);
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         r_reg <= '0;
         r_reg.state <= DACC_ST_SAMPLE;
         r_reg.res_a <= `DACC_RES_RESET;
         r_reg.res_b <= `DACC_RES_RESET;
         r_reg.chsel <= `DACC_CHSEL_RESET;
         r_reg.ref_code <= `DACC_REF_RESET;
         r_reg.mux <= {DACC_IN0_POS, DACC_IN0_NEG};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign busy_o = r_reg.busy;
   assign hold_o = r_reg.hold;
   assign bus_data_o = r_reg.data;
   assign bus_data_oe_o = r_reg.data_oe;
   assign mux_sel_o = r_reg.mux;
   assign programmable_reference_output_o = r_reg.ref_code;

endmodule // dacc_conv_ctrl

`default_nettype wire

// File: dacc_host_model.sv
// host model driving the conversion clock and trigger
`default_nettype none
module dacc_host_model
   (
   // clock
   input wire logic clk_sys_i,
   // bench requests and device status
   input wire logic go_i,
   input wire logic extra_i,
   input wire logic busy_i,
   // conversion pins
   output logic ext_clk_o,
   output logic trig_n_o,
   output logic done_o
   );
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {ext_clk_o, trig_n_o, done_o} = 3'h2;
      forever
      begin
         @(negedge clk_sys_i);
         if (go_i)
         begin
            while (busy_i)
               @(negedge clk_sys_i);
            repeat (8) @(negedge clk_sys_i);
            trig_n_o = 1'b0;
            // clock still until hold is taken
            while (!busy_i)
               @(negedge clk_sys_i);
            repeat (3) @(negedge clk_sys_i);
            trig_n_o = 1'b1;
            for (int i = 0; i < 32; i++)
            begin
               ext_clk_o = ~ext_clk_o;
               // stray trigger mid conversion, only on request
               trig_n_o = !(extra_i && i == 10);
               repeat (3) @(negedge clk_sys_i);
            end
            done_o = 1'b1;
            wait (!go_i);
            done_o = 1'b0;
         end
      end
   end
endmodule // dacc_host_model
`default_nettype wire

// File: dacc_map.svh
// constants for the dual converter conversion control and host port
`ifndef DACC_MAP_SVH
`define DACC_MAP_SVH

// external clock edges: result latch edge and busy release edge
`define DACC_CONV_CLKS 13
`define DACC_BUSY_EDGE 14

// times in picoseconds
`define DACC_SYS_CLK_PS 20000
`define DACC_ACQ_MIN_PS 62500
`define DACC_TRIG_SETUP_PS 10000

// host write word layout
`define DACC_WR_SEL_BIT 11
`define DACC_WR_CHSEL_LO 0
`define DACC_WR_CHSEL_HI 1
`define DACC_WR_PSEUDO_BIT 2
`define DACC_WR_NAP_BIT 3
`define DACC_WR_REF_LO 0
`define DACC_WR_REF_HI 9

// reset values
`define DACC_REF_RESET 10'h03FF
`define DACC_CHSEL_RESET 2'h0
`define DACC_RES_RESET 12'h0000
// pins at rest: clock low, active-low strobes and trigger high
`define DACC_PIN_IDLE 5'h0F

`endif

// File: dacc_pkg.sv
// types for the dual converter conversion control and host port
`default_nettype none

package dacc_pkg;

   typedef logic [11:0] dacc_word_t;
   typedef logic [9:0] dacc_ref_t;

   typedef enum logic [1:0] {
      DACC_IN0_POS,
      DACC_IN0_NEG,
      DACC_IN1_POS,
      DACC_IN1_NEG
   } dacc_mux_in_e;

   // converter input selector, the same for both converters
   typedef struct packed {
      dacc_mux_in_e pos;
      dacc_mux_in_e neg;
   } dacc_mux_s;

   // host pins after synchronisation
   typedef struct packed {
      logic ext_clk;
      logic trig_n;
      logic cs_n;
      logic rd_n;
      logic wr_n;
   } dacc_pins_s;

   typedef enum {
      DACC_ST_SAMPLE,
      DACC_ST_ARMED,
      DACC_ST_CONV
   } dacc_state_e;

   typedef struct packed {
      dacc_state_e state;
      logic [3:0] edge_cnt;
      logic [1:0] setup_cnt;
      logic [2:0] acq_cnt;
      logic busy;
      logic hold;
      dacc_word_t samp_a;
      dacc_word_t samp_b;
      dacc_word_t res_a;
      dacc_word_t res_b;
      logic rd_ptr;
      dacc_word_t data;
      logic data_oe;
      logic [1:0] chsel;
      logic pseudo;
      logic auto_nap;
      dacc_ref_t ref_code;
      dacc_mux_s mux;
   } dacc_ctrl_s;

endpackage

`default_nettype wire

// File: dacc_sync_edge.sv
// two-flop synchroniser with edge detect on the settled copy
`default_nettype none

module dacc_sync_edge
   #(
   parameter int WIDTH = 1,
   // rest level of each pin, so leaving reset shows no edge
   parameter logic [WIDTH-1:0] IDLE = '0
   )
   (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // asynchronous pins
   input wire logic [WIDTH-1:0] async_i,
   // synchronised level and edges
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
   );

   if (WIDTH < 1)
   begin : g_width_check
      $error("dacc_sync_edge: WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] last;
   } dacc_sync_state_s;

   dacc_sync_state_s state_reg;
   dacc_sync_state_s state_next;

   // meta feeds only the second flop
   always_comb
   begin
      state_next = state_reg;
      state_next.meta = async_i;
      state_next.sync = state_reg.meta;
      state_next.last = state_reg.sync;
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_reg <= {IDLE, IDLE, IDLE};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign level_o = state_reg.sync;
   assign rise_o = state_reg.sync & ~state_reg.last;
   assign fall_o = ~state_reg.sync & state_reg.last;

endmodule // dacc_sync_edge

`default_nettype wire

// File: tb_top.sv
// self-checking bench for the converter control block
`default_nettype none
module tb_top
   import dacc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i, reset_i, ext_clk, trig_n, cs_n, rd_n, wr_n, go, extra, done, oe, busy, hold;
   logic [11:0] wdata, rdata, conv_a, conv_b;
   logic [9:0] ref_code, rv;
   dacc_mux_s mux;
   int bad_count = 0, cmp_count = 0, cyc = 0, seed = 15;
   dacc_conv_ctrl uut (.clk_sys_i, .reset_i, .ext_clk_i(ext_clk), .sample_hold_trigger_i(trig_n), .cs_n_i(cs_n),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .bus_data_i(wdata), .bus_data_o(rdata), .bus_data_oe_o(oe),
      .conv_a_i(conv_a), .conv_b_i(conv_b), .busy_o(busy), .hold_o(hold), .mux_sel_o(mux),
      .programmable_reference_output_o(ref_code));
   // hold brackets the frame in both modes; busy starts late in auto sleep
   dacc_host_model host (.clk_sys_i, .go_i(go), .extra_i(extra), .busy_i(hold), .ext_clk_o(ext_clk),
      .trig_n_o(trig_n), .done_o(done));
   function automatic dacc_mux_s exp_mux(logic ps, logic [1:0] sel);
      if (sel == 2'h0 || (ps ? sel == 2'h3 : ^sel))
         return '{DACC_IN0_POS, DACC_IN0_NEG};
      if (!ps)
         return '{DACC_IN1_POS, DACC_IN1_NEG};
      if (sel[1])
         return '{DACC_IN1_POS, DACC_IN0_NEG};
      return '{DACC_IN1_NEG, DACC_IN0_NEG};
   endfunction
   task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(logic [11:0] w, logic sel);
      @(negedge clk_sys_i);
      {cs_n, wdata, wr_n} = {!sel, w, 1'b0};
      repeat (3) @(negedge clk_sys_i);
      wr_n = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      cs_n = 1'b1;
   endtask
   task automatic rd(logic [11:0] exp);
      @(negedge clk_sys_i);
      {cs_n, rd_n} = 2'h0;
      repeat (5) @(negedge clk_sys_i);
      chk("read word", exp, rdata);
      chk("drive enable", 12'h0001, 12'(oe));
      rd_n = 1'b1;
      repeat (3) @(negedge clk_sys_i);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      clk_sys_i = 1'b0;
      forever
         #10 clk_sys_i = ~clk_sys_i;
   end
   // ceiling well above the expected run of about 1000 cycles
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         stop_test;
      end
   end
   initial
   begin
      {go, extra, wdata, conv_a, conv_b} = '0;
      {reset_i, cs_n, rd_n, wr_n} = 4'hF;
      repeat (5) @(negedge clk_sys_i);
      reset_i = 1'b0;
      chk("reference", 12'h03FF, 12'(ref_code));
      chk("selector", 12'h0001, 12'(mux));
      for (int m = 0; m < 8; m++)
      begin
         wr({9'h000, m[2:0]}, 1'b1);
         chk("selector", 12'(exp_mux(m[2], m[1:0])), 12'(mux));
      end
      for (int k = 0; k < 4; k++)
      begin
         rv = (k == 0) ? 10'h000 : 10'($random(seed));
         wr({2'h2, rv}, 1'b1);
         chk("reference", 12'(rv), 12'(ref_code));
         wr({2'h2, ~rv}, 1'b0);
         chk("reference", 12'(rv), 12'(ref_code));
      end
      // mid-run reset restores the settings
      reset_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      reset_i = 1'b0;
      chk("reference", 12'h03FF, 12'(ref_code));
      chk("selector", 12'h0001, 12'(mux));
      for (int k = 0; k < 5; k++)
      begin
         conv_a = 12'($random(seed));
         conv_b = (k == 1) ? 12'hFFF : 12'($random(seed));
         wr((k == 3) ? 12'h008 : 12'h000, 1'b1);
         extra = (k == 2);
         go = 1'b1;
         wait (done);
         @(negedge clk_sys_i);
         go = 1'b0;
         chk("busy", 12'h0000, 12'(busy));
         // reads finish long before the next trigger
         rd(conv_a);
         rd(conv_b);
         rd(conv_a);
         cs_n = 1'b1;
         repeat (6) @(negedge clk_sys_i);
         chk("drive enable", 12'h0000, 12'(oe));
         rd_n = 1'b0;
         repeat (4) @(negedge clk_sys_i);
         rd_n = 1'b1;
         chk("read word", conv_a, rdata);
      end
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
